/* File: dsc_ctrl.sv */
// Host-side controller driving an asynchronous 64K x 4 DRAM module
`timescale 1ns/10ps
`include "dsc_consts.svh"

module dsc_ctrl
   import dsc_pkg::*;
#(
   parameter int INIT_CYCLES = `DSC_INIT_CYCLES,
   parameter int REFI_CYCLES = `DSC_REFI_CYCLES
) (
   input  wire logic                     clock,
   input  wire logic                     rst_n,
   input  wire logic                     req,
   input  wire logic                     req_we,
   input  wire logic [`DSC_ADDR_W-1:0]   req_addr,
   input  wire logic [`DSC_DQ_W-1:0]     req_wdata,
   output logic                          ready,
   output logic                          ack,
   output logic      [`DSC_DQ_W-1:0]     rdata,
   output logic                          init_done,
   output logic                          ras_n,
   output logic                          cas_n,
   output logic                          we_n,
   output logic      [`DSC_MA_W-1:0]     ma,
   input  wire logic [`DSC_DQ_W-1:0]     dq_in,
   output logic      [`DSC_DQ_W-1:0]     dq_out,
   output logic                          dq_oe
);
   localparam logic [`DSC_CNT_W-1:0] INIT_LD = `DSC_CNT_W'(INIT_CYCLES - 1);
   localparam logic [`DSC_CNT_W-1:0] REFI_LD = `DSC_CNT_W'(REFI_CYCLES - 1);
   localparam logic [`DSC_CNT_W-1:0] RP_LD   = `DSC_CNT_W'(`DSC_CYC_RP - 1);
   localparam logic [`DSC_CNT_W-1:0] RAS_LD  = `DSC_CNT_W'(`DSC_CYC_RAS - 1);
   localparam logic [`DSC_CNT_W-1:0] RCD_LD  = `DSC_CNT_W'(`DSC_CYC_RCD - 1);
   localparam logic [`DSC_CNT_W-1:0] COL_LD  = `DSC_CNT_W'(`DSC_CYC_COL - 1);
   localparam logic [`DSC_CNT_W-1:0] SMP_AT  =
      `DSC_CNT_W'(`DSC_CYC_COL - 1 - `DSC_CYC_SAMPLE);
   localparam logic [3:0]            INIT_N  = 4'(`DSC_INIT_PULSES);

   logic [1:0]             rst_sync_q;
   logic                   rst_n_s;
   dsc_regs_t              r_q;
   dsc_regs_t              r_d;
   logic                   ph_load;
   logic [`DSC_CNT_W-1:0]  ph_val;
   logic [`DSC_CNT_W-1:0]  ph_cnt;
   logic                   ph_done;
   logic                   refi_done;

   // Reset enters asynchronously, released on the clock
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n_s = rst_sync_q[1];

   // Phase timer starts loaded with the power-up pause
   dsc_timer #(
      .W       (`DSC_CNT_W),
      .RST_VAL (INIT_LD)
   ) u_phase (
      .clock (clock),
      .rst_n (rst_n_s),
      .load  (ph_load),
      .value (ph_val),
      .count (ph_cnt),
      .done  (ph_done)
   );

   // Free-running refresh spacing, one row per tick
   dsc_timer #(
      .W       (`DSC_CNT_W),
      .RST_VAL (REFI_LD)
   ) u_refi (
      .clock (clock),
      .rst_n (rst_n_s),
      .load  (refi_done),
      .value (REFI_LD),
      .count (),
      .done  (refi_done)
   );

   always_comb begin
      r_d     = r_q;
      r_d.ack = 1'b0;
      ph_load = 1'b0;
      ph_val  = '0;
      // Device output is asynchronous to our clock
      r_d.dq_s1 = dq_in;
      r_d.dq_s2 = r_q.dq_s1;
      case (r_q.st)
         DSC_S_WAIT: begin
            if (ph_done) begin
               r_d.st    = DSC_S_REF;
               r_d.ras_n = 1'b0;
               r_d.ma    = {1'b0, r_q.ref_row};
               ph_load   = 1'b1;
               ph_val    = RAS_LD;
            end
         end
         DSC_S_IDLE: begin
            if (r_q.ready && req) begin
               r_d.st     = DSC_S_ROW;
               r_d.ras_n  = 1'b0;
               r_d.ma     = req_addr[15:8];
               r_d.col    = req_addr[7:0];
               r_d.op_we  = req_we;
               r_d.dq_out = req_wdata;
               // Driving only on writes avoids a fight with read data
               r_d.dq_oe  = req_we;
               ph_load    = 1'b1;
               ph_val     = RCD_LD;
            end else if (r_q.ref_pend) begin
               r_d.ref_pend = 1'b0;
               r_d.st       = DSC_S_REF;
               r_d.ras_n    = 1'b0;
               r_d.ma       = {1'b0, r_q.ref_row};
               ph_load      = 1'b1;
               ph_val       = RAS_LD;
            end
         end
         DSC_S_ROW: begin
            if (ph_done) begin
               // Row address held for the whole delay, column strobe was high
               r_d.st    = DSC_S_COL;
               r_d.cas_n = 1'b0;
               r_d.ma    = r_q.col;
               // Write strobe falls with the column strobe: early write
               r_d.we_n  = ~r_q.op_we;
               ph_load   = 1'b1;
               ph_val    = COL_LD;
            end
         end
         DSC_S_COL: begin
            // Delay kept under its limit, so the column access bounds the sample
            if (!r_q.op_we && ph_cnt == SMP_AT) begin
               r_d.rdata = r_q.dq_s2;
            end
            if (ph_done) begin
               r_d.st    = DSC_S_PRE;
               r_d.ras_n = 1'b1;
               r_d.cas_n = 1'b1;
               // Write strobe never leaves high on reads
               r_d.we_n  = 1'b1;
               r_d.dq_oe = 1'b0;
               r_d.ack   = 1'b1;
               ph_load   = 1'b1;
               ph_val    = RP_LD;
            end
         end
         DSC_S_REF: begin
            // Row-only refresh, far below the pulse ceiling
            if (ph_done) begin
               r_d.st      = DSC_S_PRE;
               r_d.ras_n   = 1'b1;
               r_d.ref_row = r_q.ref_row + 1'b1;
               if (r_q.init_left != 4'h0) begin
                  r_d.init_left = r_q.init_left - 1'b1;
               end
               ph_load     = 1'b1;
               ph_val      = RP_LD;
            end
         end
         DSC_S_PRE: begin
            if (ph_done) begin
               if (r_q.init_left != 4'h0) begin
                  r_d.st    = DSC_S_REF;
                  r_d.ras_n = 1'b0;
                  r_d.ma    = {1'b0, r_q.ref_row};
                  ph_load   = 1'b1;
                  ph_val    = RAS_LD;
               end else begin
                  r_d.st        = DSC_S_IDLE;
                  r_d.init_done = 1'b1;
               end
            end
         end
         default: begin
            r_d.st    = DSC_S_PRE;
            r_d.ras_n = 1'b1;
            r_d.cas_n = 1'b1;
            r_d.we_n  = 1'b1;
            r_d.dq_oe = 1'b0;
            ph_load   = 1'b1;
            ph_val    = RP_LD;
         end
      endcase
      // Tick set last so it wins over the clear in the same cycle
      if (refi_done) begin
         r_d.ref_pend = 1'b1;
      end
      // Refresh owed keeps new host requests out
      r_d.ready = (r_d.st == DSC_S_IDLE) && !r_d.ref_pend;
   end

   always_ff @(posedge clock or negedge rst_n_s) begin
      if (!rst_n_s) begin
         r_q <= '{st: DSC_S_WAIT, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                  ma: 8'h00, dq_out: 4'h0, dq_oe: 1'b0, ready: 1'b0,
                  ack: 1'b0, rdata: 4'h0, init_done: 1'b0, op_we: 1'b0,
                  col: 8'h00, ref_row: 7'h00, init_left: INIT_N,
                  ref_pend: 1'b0, dq_s1: 4'h0, dq_s2: 4'h0};
      end else begin
         r_q <= r_d;
      end
   end

   assign ready     = r_q.ready;
   assign ack       = r_q.ack;
   assign rdata     = r_q.rdata;
   assign init_done = r_q.init_done;
   assign ras_n     = r_q.ras_n;
   assign cas_n     = r_q.cas_n;
   assign we_n      = r_q.we_n;
   assign ma        = r_q.ma;
   assign dq_out    = r_q.dq_out;
   assign dq_oe     = r_q.dq_oe;
endmodule : dsc_ctrl

/* File: dsc_consts.svh */
// Timing and layout constants for the DRAM strobe controller
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH

`define DSC_MAX(a, b)     (((a) > (b)) ? (a) : (b))
`define DSC_CEIL(t, p)    (((t) + (p) - 1) / (p))
`define DSC_FLOOR(t, p)   ((t) / (p))

`define DSC_CLK_NS        8
`define DSC_ADDR_W        16
`define DSC_MA_W          8
`define DSC_DQ_W          4
`define DSC_REF_ROW_W     7
`define DSC_CNT_W         16
`define DSC_SYNC_STAGES   2

`define DSC_T_INIT_US     500
`define DSC_INIT_CYCLES   `DSC_CEIL(`DSC_T_INIT_US * 1000, `DSC_CLK_NS)
`define DSC_INIT_PULSES   8
`define DSC_T_REF_MS      2
`define DSC_REF_ROWS      128
`define DSC_T_REFI_NS     (`DSC_T_REF_MS * 1000000 / `DSC_REF_ROWS)
`define DSC_REFI_CYCLES   `DSC_FLOOR(`DSC_T_REFI_NS, `DSC_CLK_NS)

`define DSC_T_RP_NS       100
`define DSC_T_RAS_NS      150
`define DSC_T_RAS_MAX_NS  10000
`define DSC_T_CPN_NS      35
`define DSC_T_CSH_NS      150
`define DSC_T_RSH_NS      75
`define DSC_T_RCD_NS      30
`define DSC_T_RCD_MAX_NS  75
`define DSC_T_RAH_NS      20
`define DSC_T_CAC_NS      75
`define DSC_T_WP_NS       45
`define DSC_T_DHR_NS      95

`define DSC_CYC_RP        `DSC_CEIL(`DSC_T_RP_NS, `DSC_CLK_NS)
`define DSC_CYC_RAS       `DSC_CEIL(`DSC_T_RAS_NS, `DSC_CLK_NS)
`define DSC_CYC_RAS_MAX   `DSC_FLOOR(`DSC_T_RAS_MAX_NS, `DSC_CLK_NS)
`define DSC_CYC_CPN       `DSC_CEIL(`DSC_T_CPN_NS, `DSC_CLK_NS)
`define DSC_CYC_CSH       `DSC_CEIL(`DSC_T_CSH_NS, `DSC_CLK_NS)
`define DSC_CYC_RSH       `DSC_CEIL(`DSC_T_RSH_NS, `DSC_CLK_NS)
`define DSC_CYC_RCD       `DSC_MAX(`DSC_CEIL(`DSC_T_RCD_NS, `DSC_CLK_NS), \
                                   `DSC_CEIL(`DSC_T_RAH_NS, `DSC_CLK_NS))
`define DSC_CYC_CAC       `DSC_CEIL(`DSC_T_CAC_NS, `DSC_CLK_NS)
`define DSC_CYC_WP        `DSC_CEIL(`DSC_T_WP_NS, `DSC_CLK_NS)
`define DSC_CYC_DHR       `DSC_CEIL(`DSC_T_DHR_NS, `DSC_CLK_NS)
`define DSC_CYC_SAMPLE    (`DSC_CYC_CAC + `DSC_SYNC_STAGES)
`define DSC_CYC_COL       `DSC_MAX(`DSC_MAX(`DSC_CYC_RSH, `DSC_CYC_SAMPLE + 1), \
                          `DSC_MAX(`DSC_CYC_CSH - `DSC_CYC_RCD, \
                          `DSC_MAX(`DSC_CYC_RAS - `DSC_CYC_RCD, \
                                   `DSC_CYC_DHR - `DSC_CYC_RCD)))

`endif

/* File: dsc_pkg.sv */
// Types of the DRAM strobe controller
package dsc_pkg;
   typedef enum logic [2:0] {
      DSC_S_WAIT = 3'b000,
      DSC_S_IDLE = 3'b001,
      DSC_S_ROW  = 3'b010,
      DSC_S_COL  = 3'b011,
      DSC_S_REF  = 3'b100,
      DSC_S_PRE  = 3'b101
   } dsc_state_t;

   typedef struct packed {
      dsc_state_t  st;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic [7:0]  ma;
      logic [3:0]  dq_out;
      logic        dq_oe;
      logic        ready;
      logic        ack;
      logic [3:0]  rdata;
      logic        init_done;
      logic        op_we;
      logic [7:0]  col;
      logic [6:0]  ref_row;
      logic [3:0]  init_left;
      logic        ref_pend;
      logic [3:0]  dq_s1;
      logic [3:0]  dq_s2;
   } dsc_regs_t;
endpackage : dsc_pkg

/* File: dsc_timer.sv */
// Loadable down counter used for strobe phases and refresh spacing
`timescale 1ns/10ps
module dsc_timer #(
   parameter int           W       = 16,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic         load,
   input  wire logic [W-1:0] value,
   output logic      [W-1:0] count,
   output logic              done
);
   logic [W-1:0] cnt_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= RST_VAL;
      end else if (load) begin
         cnt_q <= value;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   assign count = cnt_q;
   assign done  = (cnt_q == '0);
endmodule : dsc_timer

/* File: dsc_ctrl_chk.sv */
// Strobe timing checker bound to the DRAM strobe controller
`timescale 1ns/10ps
module dsc_ctrl_chk #(
   parameter int INIT_CYCLES = 20,
   parameter int REFI_CYCLES = 200
) (
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic       init_done,
   input wire logic       ras_n,
   input wire logic       cas_n,
   input wire logic       we_n,
   input wire logic [3:0] dq_out,
   input wire logic       dq_oe
);
   logic [15:0] lo_q;
   logic [15:0] gap_q;
   logic [31:0] cyc_q;
   logic [3:0]  nras_q;

   // Row low time, time since last row cycle, cycles since reset, row cycles
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         lo_q   <= 16'h0000;
         gap_q  <= 16'h0000;
         cyc_q  <= 32'h00000000;
         nras_q <= 4'h0;
      end else begin
         lo_q   <= ras_n ? 16'h0000 : lo_q + 16'h0001;
         gap_q  <= (!ras_n && lo_q == 16'h0000) ? 16'h0000 : gap_q + 16'h0001;
         cyc_q  <= cyc_q + 32'h00000001;
         nras_q <= (!ras_n && lo_q == 16'h0000 && nras_q != 4'hF) ? nras_q + 4'h1 : nras_q;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   chk_ras_precharge: assert property ($rose(ras_n) |-> ras_n[*8] ##1 ras_n[*5])
      else $error("row strobe precharge too short");
   chk_ras_width: assert property (
      $fell(ras_n) |-> !ras_n[*8] ##1 !ras_n[*8] ##1 !ras_n[*3])
      else $error("row strobe pulse too short");
   chk_ras_max: assert property (!ras_n |-> lo_q < 16'h04E2)
      else $error("row strobe pulse too long");
   chk_cas_gap: assert property ($rose(cas_n) |-> cas_n[*5])
      else $error("column strobe high time too short");
   chk_cas_hold: assert property ($rose(cas_n) |-> lo_q >= 16'h0013)
      else $error("column strobe released too early");
   chk_ras_hold: assert property ($fell(cas_n) |-> !ras_n[*8] ##1 !ras_n[*2])
      else $error("row strobe released too early after column strobe");
   chk_rcd_window: assert property (
      $fell(cas_n) |-> lo_q inside {[16'h0004:16'h0009]})
      else $error("row to column delay out of window");
   chk_cas_only: assert property (!cas_n |-> !ras_n)
      else $error("column strobe low without row strobe");
   chk_read_we: assert property (
      $fell(ras_n) && !dq_oe |-> we_n[*8] ##1 we_n[*8] ##1 we_n[*6])
      else $error("write strobe low during read");
   chk_write_lead: assert property (
      $rose(ras_n) && !$past(we_n) |-> !$past(we_n, 6))
      else $error("write strobe too late before row strobe rise");
   chk_we_width: assert property ($fell(we_n) |-> !we_n[*6])
      else $error("write pulse too short");
   chk_data_hold: assert property ($fell(ras_n) && dq_oe |=>
      ($stable(dq_out) && dq_oe)[*8] ##1 ($stable(dq_out) && dq_oe)[*4])
      else $error("write data not held");
   chk_init_pause: assert property (
      $fell(ras_n) && nras_q == 4'h0 |-> cyc_q >= INIT_CYCLES)
      else $error("first row cycle before power-up pause");
   chk_init_count: assert property ($rose(init_done) |-> nras_q >= 4'h8)
      else $error("fewer than eight warm-up cycles");
   chk_refresh_gap: assert property (init_done |-> gap_q < REFI_CYCLES + 64)
      else $error("refresh overdue");

   cover_write: cover property ($fell(ras_n) && dq_oe);
   cover_read: cover property ($fell(cas_n) && we_n);
   cover_refresh: cover property ($rose(ras_n) && $past(cas_n));
endmodule : dsc_ctrl_chk

bind dsc_ctrl dsc_ctrl_chk #(.INIT_CYCLES(INIT_CYCLES), .REFI_CYCLES(REFI_CYCLES)) chk_u (
   .clock, .rst_n, .init_done, .ras_n, .cas_n, .we_n, .dq_out, .dq_oe);

/* File: dsc_dram_model.sv */
// Behavioural 64K x 4 DRAM at the far side of the strobe controller
`timescale 1ns/10ps
module dsc_dram_model (
   input  wire logic       ras_n,
   input  wire logic       cas_n,
   input  wire logic       we_n,
   input  wire logic [7:0] ma,
   input  wire logic [3:0] d,
   output logic      [3:0] q
);
   logic [3:0] mem [0:65535];
   logic [7:0] row_q;
   logic [3:0] last_q = 4'h0;

   initial q = 4'h0;
   // Latch just after the edge, address moves on the same clock edge
   always @(negedge ras_n) begin
      #1;
      row_q = ma;
   end
   always @(negedge cas_n) begin
      #1;
      if (!ras_n && !we_n) begin
         mem[{row_q, ma}] = d; // Early write, output stays off
      end else if (!ras_n) begin
         q = ~last_q;
         last_q = mem[{row_q, ma}];
         q <= #74 last_q; // Valid a fixed time after column strobe
      end
   end
   // No pull on the lines: a released output shows the inverse
   always @(posedge cas_n) q <= #40 ~last_q;
endmodule : dsc_dram_model

/* File: test_dsc_ctrl.sv */
// Self-checking testbench for the DRAM strobe controller
`timescale 1ns/10ps
module test_dsc_ctrl;
   localparam int INIT_C = 20;
   localparam int REFI_C = 200;
   logic        clock, rst_n, req, req_we, ready, ack, init_done;
   logic        ras_n, cas_n, we_n, dq_oe;
   logic [15:0] req_addr;
   logic [7:0]  ma;
   logic [3:0]  req_wdata, rdata, dq_in, dq_out;
   int          n_mismatch = 0, n_checks = 0, n_ras = 0;

   dsc_ctrl #(.INIT_CYCLES(INIT_C), .REFI_CYCLES(REFI_C)) dut_u (.clock, .rst_n, .req,
      .req_we, .req_addr, .req_wdata, .ready, .ack, .rdata, .init_done, .ras_n, .cas_n,
      .we_n, .ma, .dq_in, .dq_out, .dq_oe);
   dsc_dram_model mem_u (.ras_n, .cas_n, .we_n, .ma, .d(dq_out), .q(dq_in));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(negedge ras_n) n_ras++;

   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : close_out

   // Entered at a falling edge; bounded so a stuck design cannot hang here
   task automatic wait_ready;
      for (int i = 0; i < 2000 && ready !== 1'b1; i++) @(negedge clock);
      check("ready", ready, 1'b1);
   endtask : wait_ready

   task automatic access(input logic we, input logic [15:0] a, input logic [3:0] wd,
                         output logic [3:0] rd);
      int k;
      req_we = we;
      req_addr = a;
      req_wdata = wd;
      req = 1'b1;
      wait_ready();
      @(negedge clock);
      req = 1'b0;
      for (k = 1; k < 40 && ack !== 1'b1; k++) @(negedge clock);
      check("ack_delay", 16'(k), 16'h0014);
      rd = rdata;
   endtask : access

   task automatic t_init;
      wait_ready();
      check("init_done", init_done, 1'b1);
      check("warmup", n_ras >= 8, 1'b1);
   endtask : t_init

   // Corner addresses, back-to-back writes then reads
   task automatic t_data;
      logic [15:0] adr [4] = '{16'h0000, 16'hFFFF, 16'h5AA5, 16'h00FF};
      logic [3:0]  dat [4] = '{4'hA, 4'h5, 4'hF, 4'h0};
      logic [3:0]  rd;
      foreach (adr[i]) access(1'b1, adr[i], dat[i], rd);
      foreach (adr[i]) begin
         access(1'b0, adr[i], 4'h3, rd);
         check("rdata", rd, dat[i]);
      end
   endtask : t_data

   task automatic t_refresh;
      int base;
      base = n_ras;
      repeat (3 * REFI_C) @(negedge clock);
      check("refreshes", n_ras - base >= 2, 1'b1);
   endtask : t_refresh

   // Reset in the middle of a write, then the memory must still answer
   task automatic t_reset;
      logic [3:0] rd;
      req_we = 1'b1;
      req_addr = 16'h1234;
      req_wdata = 4'h7;
      req = 1'b1;
      wait_ready();
      repeat (6) @(negedge clock);
      rst_n = 1'b0;
      req = 1'b0;
      @(negedge clock);
      check("rst_out", {ras_n, cas_n, we_n, dq_oe, ready, init_done, ack}, 7'h70);
      n_ras = 0;
      repeat (5) @(negedge clock);
      rst_n = 1'b1;
      t_init();
      access(1'b0, 16'h5AA5, 4'h0, rd);
      check("rdata_rst", rd, 4'hF);
   endtask : t_reset

   initial begin
      rst_n = 1'b0;
      req = 1'b0;
      req_we = 1'b0;
      req_addr = 16'h0000;
      req_wdata = 4'h0;
      repeat (5) @(negedge clock);
      rst_n = 1'b1;
      t_init();
      t_data();
      t_refresh();
      t_reset();
      close_out();
   end

   initial begin
      #(20000 * 8);
      n_mismatch++;
      close_out();
   end
endmodule : test_dsc_ctrl
